/* File: tmc_map.svh */
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
`define TMC_OFF_CTRL 8'h00
`define TMC_OFF_COUNT 8'h04
`define TMC_OFF_CMP 8'h08
`define TMC_OFF_FLAGS 8'h0C
`define TMC_OFF_IRQEN 8'h10
`define TMC_OFF_PORT 8'h14
`define TMC_FLG_OVF 0
`define TMC_FLG_CMP 1
`define TMC_PORT_DATA 0
`define TMC_PORT_DIR 1
`define TMC_PORT_GIE 2
`define TMC_PORT_LATCH 3
`define TMC_CTRL_FORCE 7
`define TMC_CTRL_RST 8'h00
`define TMC_CNT_RST 8'h00
`define TMC_CNT_MAX 8'hFF
`define TMC_CNT_BOT 8'h00
`define TMC_PRE_RST 10'h000
`define TMC_PRE_M8 10'h007
`define TMC_PRE_M64 10'h03F
`define TMC_PRE_M256 10'h0FF
`define TMC_PRE_M1024 10'h3FF
`endif

/* File: tmc_pkg.sv */
// Types shared by the timer and its users.
package tmc_pkg;
   typedef enum logic [1:0] {
      TMC_WGM_NORMAL = 2'h0,
      TMC_WGM_PCPWM = 2'h1,
      TMC_WGM_CTC = 2'h2,
      TMC_WGM_FAST = 2'h3
   } tmc_wgm_t;
   typedef struct packed {
      logic force_strobe;
      logic [1:0] compare_action_field;
      tmc_wgm_t waveform_mode_field;
      logic [2:0] clock_select_field;
   } tmc_ctrl_t;
   typedef struct packed {
      logic oe;
      logic out;
   } tmc_pin_t;
endpackage : tmc_pkg

/* File: tmc_timer.sv */
// Eight-bit timer with one compare channel behind an APB slave.
//
// Operation
// R1 - Clock select zero stops the counter; no timer ticks reach it.
// R2 - Each tick clears, increments or decrements the counter per mode.
// R3 - Software may read and write the counter at any time.
// R4 - A counter write beats a same-cycle count or clear.
// R5 - Top shows counter at maximum, bottom shows counter at zero.
// R6 - Counter and compare value are compared continuously for equality.
// R7 - A match sets the compare flag on the following tick.
// R8 - Flag, enable and global enable request an interrupt; service clears.
// R9 - Writing one to the compare flag clears it; zero leaves it.
// R10 - PWM modes double-buffer the compare value, loaded at top.
// R11 - Compare accesses reach the buffer in PWM modes, else active.
// R12 - Force strobe acts like a match on the latch only, non-PWM.
// R13 - A counter write blocks every match on the next tick.
// R14 - The action field is unbuffered and governs the next match.
// R15 - Reset clears the output latch; mode changes keep it.
// R16 - Nonzero action field routes the latch to the pin; direction stays.
// R17 - Action field zero leaves the latch unchanged on a match.
// R18 - Counting depends only on the mode field, never on action.
// R19 - Normal mode counts up only and wraps from FF to 00.
// R20 - Normal mode sets overflow when the counter becomes zero.
// R21 - Software should preset the latch before enabling the pin.
// R22 - Mode 2 clears the counter on a compare match.
// R23 - Mode 3 counts zero to maximum and restarts: fast PWM.
// R24 - Mode 1 counts up to maximum and back down: phase correct.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_timer #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clk_pin,
   input wire logic ovf_irq_ack,
   input wire logic cmp_irq_ack,
   output logic ovf_irq,
   output logic cmp_irq,
   output tmc_pkg::tmc_pin_t oc_pin
);
   import tmc_pkg::*;

   // Latch update for a match in the non-PWM modes.
   function automatic logic act_nonpwm(input logic [1:0] act,
                                       input logic cur);
      unique case (act)
         2'h0: act_nonpwm = cur;
         2'h1: act_nonpwm = ~cur;
         2'h2: act_nonpwm = 1'b0;
         default: act_nonpwm = 1'b1;
      endcase
   endfunction : act_nonpwm

   tmc_ctrl_t ctrl_r, ctrl_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [7:0] ocr_r, ocr_nxt;
   logic [7:0] ocr_buf_r, ocr_buf_nxt;
   logic down_r, down_nxt;
   logic block_r, block_nxt;
   logic ovf_flag_r, ovf_flag_nxt;
   logic cmp_flag_r, cmp_flag_nxt;
   logic ovf_en_r, ovf_en_nxt;
   logic cmp_en_r, cmp_en_nxt;
   logic port_data_r, port_data_nxt;
   logic port_dir_r, port_dir_nxt;
   logic gie_r, gie_nxt;
   logic latch_r, latch_nxt;
   logic [9:0] pre_r;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic ovf_irq_r, ovf_irq_nxt;
   logic cmp_irq_r, cmp_irq_nxt;
   tmc_pin_t pin_r, pin_nxt;

   logic wr, tick, pwm, match, hit, top, bottom, force_hit, ovf_set;
   logic cnt_wr, cmp_wr, ctrl_wr, flg_wr, en_wr, port_wr;
   logic [7:0] wbyte;
   tmc_wgm_t mode;
   logic [1:0] act;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ovf_irq = ovf_irq_r;
   assign cmp_irq = cmp_irq_r;
   assign oc_pin = pin_r;

   // Decode of the access phase; a write lands only in its completing cycle.
   assign wr = psel & penable & pready_r & pwrite;
   assign wbyte = pwdata[7:0];
   assign ctrl_wr = wr & (paddr == ADDR_W'(`TMC_OFF_CTRL));
   assign cnt_wr = wr & (paddr == ADDR_W'(`TMC_OFF_COUNT));
   assign cmp_wr = wr & (paddr == ADDR_W'(`TMC_OFF_CMP));
   assign flg_wr = wr & (paddr == ADDR_W'(`TMC_OFF_FLAGS));
   assign en_wr = wr & (paddr == ADDR_W'(`TMC_OFF_IRQEN));
   assign port_wr = wr & (paddr == ADDR_W'(`TMC_OFF_PORT));

   // Tick source. External edges are seen only after two flops, so a
   // pin edge reaches the counter two to three clocks later.
   always_comb begin
      unique case (ctrl_r.clock_select_field)
         3'h0: tick = 1'b0; // see R1
         3'h1: tick = 1'b1;
         3'h2: tick = (pre_r & `TMC_PRE_M8) == `TMC_PRE_M8;
         3'h3: tick = (pre_r & `TMC_PRE_M64) == `TMC_PRE_M64;
         3'h4: tick = (pre_r & `TMC_PRE_M256) == `TMC_PRE_M256;
         3'h5: tick = (pre_r & `TMC_PRE_M1024) == `TMC_PRE_M1024;
         3'h6: tick = ext_s3_r & ~ext_s2_r;
         default: tick = ext_s2_r & ~ext_s3_r;
      endcase
   end

   // Comparator and extreme-value indications.
   assign mode = ctrl_r.waveform_mode_field;
   assign act = ctrl_r.compare_action_field; // see R14
   assign pwm = (mode == TMC_WGM_FAST) | (mode == TMC_WGM_PCPWM);
   assign top = cnt_r == `TMC_CNT_MAX; // see R5
   assign bottom = cnt_r == `TMC_CNT_BOT; // see R5
   assign match = (cnt_r == ocr_r) & ~block_r; // see R6
   assign hit = tick & match; // see R13
   assign force_hit = ctrl_wr & wbyte[`TMC_CTRL_FORCE] & ~pwm; // see R12

   // Counter, direction and match blocking. Only the mode field steers
   // the sequence, so the action field cannot disturb counting.
   always_comb begin
      cnt_nxt = cnt_r;
      down_nxt = down_r;
      if (tick) begin // see R2
         unique case (mode) // see R18
            TMC_WGM_NORMAL: cnt_nxt = cnt_r + 8'h01; // see R19
            TMC_WGM_CTC: cnt_nxt = match ? `TMC_CNT_BOT
                                         : cnt_r + 8'h01; // see R22
            TMC_WGM_FAST: cnt_nxt = cnt_r + 8'h01; // see R23
            TMC_WGM_PCPWM: begin // see R24
               if (down_r && bottom) begin
                  down_nxt = 1'b0;
                  cnt_nxt = cnt_r + 8'h01;
               end else if (!down_r && top) begin
                  down_nxt = 1'b1;
                  cnt_nxt = cnt_r - 8'h01;
               end else begin
                  cnt_nxt = down_r ? cnt_r - 8'h01 : cnt_r + 8'h01;
               end
            end
         endcase
      end
      if (cnt_wr) begin
         cnt_nxt = wbyte; // see R3 see R4
      end
      if (cnt_wr) begin
         block_nxt = 1'b1; // see R13
      end else if (tick) begin
         block_nxt = 1'b0;
      end else begin
         block_nxt = block_r;
      end
   end

   // Overflow fires when a tick really brings the counter to zero; a
   // clear on match in mode 2 is not an overflow unless the counter stood at top.
   assign ovf_set = tick & ~cnt_wr & ~bottom & (cnt_nxt == `TMC_CNT_BOT)
                    & ((mode != TMC_WGM_CTC) | top); // see R20

   // Flags: hardware set wins over a same-cycle clear.
   always_comb begin
      ovf_flag_nxt = ovf_set | (ovf_flag_r & ~ovf_irq_ack
                     & ~(flg_wr & wbyte[`TMC_FLG_OVF]));
      cmp_flag_nxt = hit | (cmp_flag_r & ~cmp_irq_ack // see R7 see R8
                     & ~(flg_wr & wbyte[`TMC_FLG_CMP])); // see R9
   end

   // Compare value and its buffer. PWM writes wait in the buffer until
   // the counter passes its top, so a pulse is never cut short.
   always_comb begin
      ocr_nxt = ocr_r;
      ocr_buf_nxt = ocr_buf_r;
      if (pwm && tick && top) begin
         ocr_nxt = ocr_buf_r; // see R10
      end
      if (cmp_wr) begin
         ocr_buf_nxt = wbyte; // see R11
         if (!pwm) begin
            ocr_nxt = wbyte; // see R10 see R11
         end
      end
   end

   // Output latch. The action field is read live each time.
   always_comb begin
      latch_nxt = latch_r;
      if (!pwm) begin
         if (hit || force_hit) begin
            latch_nxt = act_nonpwm(act, latch_r); // see R12 see R17
         end
      end else if (mode == TMC_WGM_FAST) begin
         if (hit) begin
            latch_nxt = act_nonpwm(act, latch_r);
         end else if (tick && top && act[1]) begin
            latch_nxt = ~act[0];
         end
      end else if (hit && act != 2'h0) begin // see R17
         latch_nxt = (act == 2'h1) ? ~latch_r : (act[0] ^ down_r);
      end
   end

   // Software-held control bits.
   always_comb begin
      ctrl_nxt = ctrl_r;
      ovf_en_nxt = ovf_en_r;
      cmp_en_nxt = cmp_en_r;
      port_data_nxt = port_data_r;
      port_dir_nxt = port_dir_r;
      gie_nxt = gie_r;
      if (ctrl_wr) begin
         ctrl_nxt = tmc_ctrl_t'(wbyte);
         ctrl_nxt.force_strobe = 1'b0;
      end
      if (en_wr) begin
         ovf_en_nxt = wbyte[`TMC_FLG_OVF];
         cmp_en_nxt = wbyte[`TMC_FLG_CMP];
      end
      if (port_wr) begin
         port_data_nxt = wbyte[`TMC_PORT_DATA];
         port_dir_nxt = wbyte[`TMC_PORT_DIR];
         gie_nxt = wbyte[`TMC_PORT_GIE];
      end
   end

   // Requests and pin from next values, so outputs line up with state.
   always_comb begin
      ovf_irq_nxt = ovf_flag_nxt & ovf_en_nxt & gie_nxt;
      cmp_irq_nxt = cmp_flag_nxt & cmp_en_nxt & gie_nxt; // see R8
      pin_nxt.oe = port_dir_nxt; // see R16
      pin_nxt.out = (ctrl_nxt.compare_action_field != 2'h0)
                    ? latch_nxt : port_data_nxt; // see R16
   end

   // APB answer prepared in the setup cycle; one wait-free access phase.
   always_comb begin
      pready_nxt = psel & ~penable;
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (psel && !penable) begin
         unique case (paddr)
            ADDR_W'(`TMC_OFF_CTRL): prdata_nxt[6:0] = ctrl_r[6:0];
            ADDR_W'(`TMC_OFF_COUNT): prdata_nxt[7:0] = cnt_r; // see R3
            ADDR_W'(`TMC_OFF_CMP):
               prdata_nxt[7:0] = pwm ? ocr_buf_r : ocr_r; // see R11
            ADDR_W'(`TMC_OFF_FLAGS): begin
               prdata_nxt[`TMC_FLG_OVF] = ovf_flag_r;
               prdata_nxt[`TMC_FLG_CMP] = cmp_flag_r;
            end
            ADDR_W'(`TMC_OFF_IRQEN): begin
               prdata_nxt[`TMC_FLG_OVF] = ovf_en_r;
               prdata_nxt[`TMC_FLG_CMP] = cmp_en_r;
            end
            ADDR_W'(`TMC_OFF_PORT): begin
               prdata_nxt[`TMC_PORT_DATA] = port_data_r;
               prdata_nxt[`TMC_PORT_DIR] = port_dir_r;
               prdata_nxt[`TMC_PORT_GIE] = gie_r;
               prdata_nxt[`TMC_PORT_LATCH] = latch_r;
            end
            default: pslverr_nxt = 1'b1;
         endcase
      end
   end

   // Free-running prescaler and external pin synchroniser.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= `TMC_PRE_RST;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         pre_r <= pre_r + 10'h001;
         ext_s1_r <= ext_clk_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // State registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tmc_ctrl_t'(`TMC_CTRL_RST);
         cnt_r <= `TMC_CNT_RST;
         ocr_r <= `TMC_CNT_RST;
         ocr_buf_r <= `TMC_CNT_RST;
         down_r <= 1'b0;
         block_r <= 1'b0;
         ovf_flag_r <= 1'b0;
         cmp_flag_r <= 1'b0;
         ovf_en_r <= 1'b0;
         cmp_en_r <= 1'b0;
         port_data_r <= 1'b0;
         port_dir_r <= 1'b0;
         gie_r <= 1'b0;
         latch_r <= 1'b0; // see R15
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         ovf_irq_r <= 1'b0;
         cmp_irq_r <= 1'b0;
         pin_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cnt_r <= cnt_nxt;
         ocr_r <= ocr_nxt;
         ocr_buf_r <= ocr_buf_nxt;
         down_r <= down_nxt;
         block_r <= block_nxt;
         ovf_flag_r <= ovf_flag_nxt;
         cmp_flag_r <= cmp_flag_nxt;
         ovf_en_r <= ovf_en_nxt;
         cmp_en_r <= cmp_en_nxt;
         port_data_r <= port_data_nxt;
         port_dir_r <= port_dir_nxt;
         gie_r <= gie_nxt;
         latch_r <= latch_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
         ovf_irq_r <= ovf_irq_nxt;
         cmp_irq_r <= cmp_irq_nxt;
         pin_r <= pin_nxt;
      end
   end

   // Checks on the counter, flags and pin.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_HALT: assert property ( // see R1
      ctrl_r.clock_select_field == 3'h0 && !cnt_wr |=> $stable(cnt_r))
      else $error("Counter moved while stopped.");
   AST_CNT_WRITE: assert property ( // see R4
      cnt_wr |=> cnt_r == $past(wbyte))
      else $error("Counter write lost.");
   AST_MATCH_FLAG: assert property ( // see R7
      tick && cnt_r == ocr_r && !block_r |=> cmp_flag_r)
      else $error("Match flag not set.");
   AST_BLOCK: assert property ( // see R13
      cnt_wr && !cmp_flag_r ##1 !cnt_wr && !cmp_flag_r |=> !cmp_flag_r)
      else $error("Match not blocked after counter write.");
   AST_W1C: assert property ( // see R9
      flg_wr && wbyte[`TMC_FLG_CMP] && !hit |=> !cmp_flag_r)
      else $error("Compare flag not cleared.");
   AST_NORMAL_WRAP: assert property ( // see R20
      tick && mode == TMC_WGM_NORMAL && top && !cnt_wr
      |=> cnt_r == `TMC_CNT_BOT && ovf_flag_r)
      else $error("Normal wrap or overflow wrong.");
   AST_CTC_CLEAR: assert property ( // see R22
      tick && mode == TMC_WGM_CTC && cnt_r == ocr_r && !block_r && !cnt_wr
      |=> cnt_r == `TMC_CNT_BOT)
      else $error("Counter not cleared on match.");
   AST_FORCE: assert property ( // see R12
      force_hit && !hit && !cmp_flag_r
      |=> !cmp_flag_r && latch_r == act_nonpwm($past(act), $past(latch_r)))
      else $error("Force strobe misbehaved.");
   AST_PIN: assert property ( // see R16
      pin_r.out == ((act != 2'h0) ? latch_r : port_data_r)
      && pin_r.oe == port_dir_r)
      else $error("Pin source wrong.");
   AST_IRQ: assert property ( // see R8
      cmp_irq_r == (cmp_flag_r && cmp_en_r && gie_r))
      else $error("Compare request wrong.");

   COV_WRAP: cover property (tick && mode == TMC_WGM_NORMAL && top);
   COV_CTC: cover property (tick && mode == TMC_WGM_CTC && match);
   COV_TURN: cover property (mode == TMC_WGM_PCPWM && tick && top);
   COV_FORCE: cover property (force_hit);
endmodule : tmc_timer

/* File: tb.sv */
// Self-checking testbench of the eight-bit timer with one compare channel.
`timescale 1ns/1ps
`include "tmc_map.svh"
module tb;
   import tmc_pkg::*;
   localparam logic [7:0] A_CTL = `TMC_OFF_CTRL;
   localparam logic [7:0] A_CNT = `TMC_OFF_COUNT;
   localparam logic [7:0] A_CMP = `TMC_OFF_CMP;
   localparam logic [7:0] A_FLG = `TMC_OFF_FLAGS;
   localparam logic [7:0] A_IEN = `TMC_OFF_IRQEN;
   localparam logic [7:0] A_PRT = `TMC_OFF_PORT;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, ovf_irq, cmp_irq;
   logic ext_clk_pin = 1'b0;
   logic ovf_irq_ack = 1'b0;
   logic cmp_irq_ack = 1'b0;
   tmc_pin_t oc_pin;
   int err_count = 0;
   int n_compared = 0;
   logic [32:0] q_exp[$];
   string q_nm[$];
   logic [31:0] seed = 32'h000103A0;

   tmc_timer #(.ADDR_W(8)) u_tmc_timer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clk_pin(ext_clk_pin), .ovf_irq_ack(ovf_irq_ack),
      .cmp_irq_ack(cmp_irq_ack), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq),
      .oc_pin(oc_pin));

   // The clock toggles every half period of 2.5 ns.
   initial begin
      forever #2.5 pclk = ~pclk;
   end

   task automatic check(input string nm, input logic [32:0] seen,
                        input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_sim;
      if (err_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic logic [31:0] ctl(input logic f, input logic [1:0] act,
                                       input logic [1:0] md,
                                       input logic [2:0] cs);
      tmc_ctrl_t c;
      c = '{f, act, tmc_wgm_t'(md), cs};
      return {24'h000000, c};
   endfunction : ctl

   // One APB transfer; the request stands until pready is seen high.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   // A read notes its expected word, with the error bit on top, first.
   task automatic rd(input logic [7:0] a, input logic [32:0] e,
                     input string nm);
      q_exp.push_back(e);
      q_nm.push_back(nm);
      xfer(1'b0, a, 32'h00000000);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // Read data is judged at the edge that completes the access.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (q_exp.size() == 0) begin
            err_count++;
         end else begin
            check(q_nm.pop_front(), {pslverr, prdata}, q_exp.pop_front());
         end
      end
   end

   // The span allows over twenty times the length of the sequence below.
   initial begin
      #100000;
      err_count++;
      end_sim();
   end

   initial begin
      cyc(12);
      presetn <= 1'b1;
      rd(A_CTL, 33'h0, "ctrl rst");
      rd(A_CNT, 33'h0, "count rst");
      rd(A_FLG, 33'h0, "flags rst");
      rd(A_PRT, 33'h0, "port rst");
      rd(8'h40, 33'h100000000, "unmapped");
      // With the clock stopped, written counts must hold still.
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         wr(A_CNT, {24'h000000, seed[7:0]});
         cyc(6);
         rd(A_CNT, {25'h0, seed[7:0]}, "count held");
      end
      for (int m = 0; m < 4; m++) begin
         wr(A_CTL, ctl(1'b0, 2'h0, 2'(m), 3'h0));
         rd(A_CTL, {1'b0, ctl(1'b0, 2'h0, 2'(m), 3'h0)}, "mode");
      end
      // Five slow rising edges on the event pin give five ticks.
      wr(A_CNT, 32'h00000010);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h7));
      wr(A_CMP, 32'h000000F5);
      rd(A_CMP, 33'hF5, "cmp direct");
      repeat (5) begin
         cyc(4);
         ext_clk_pin <= 1'b1;
         cyc(4);
         ext_clk_pin <= 1'b0;
      end
      cyc(8);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
      rd(A_CNT, 33'h15, "count ext");
      // Normal run across the compare value and the wrap.
      wr(A_CNT, 32'h000000F0);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h1));
      cyc(30);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
      rd(A_FLG, 33'h3, "flags run");
      wr(A_IEN, 32'h00000003);
      wr(A_PRT, 32'h00000004);
      cyc(2);
      check("cmp irq", {32'h0, cmp_irq}, 33'h1);
      check("ovf irq", {32'h0, ovf_irq}, 33'h1);
      @(posedge pclk);
      cmp_irq_ack <= 1'b1;
      @(posedge pclk);
      cmp_irq_ack <= 1'b0;
      cyc(2);
      check("cmp irq ack", {32'h0, cmp_irq}, 33'h0);
      wr(A_IEN, 32'h00000000);
      cyc(2);
      check("ovf irq mask", {32'h0, ovf_irq}, 33'h0);
      rd(A_FLG, 33'h1, "flags ack");
      wr(A_FLG, 32'h00000000);
      rd(A_FLG, 33'h1, "flags w0");
      wr(A_FLG, 32'h00000001);
      rd(A_FLG, 33'h0, "flags w1c");
      // A count write equal to the compare value hides the first match.
      wr(A_CMP, 32'h00000040);
      wr(A_CNT, 32'h00000040);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h1));
      cyc(20);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
      rd(A_FLG, 33'h0, "flags blocked");
      // Clear on match must keep the count from ever wrapping.
      wr(A_CNT, 32'h00000000);
      wr(A_CMP, 32'h00000010);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h2, 3'h1));
      cyc(300);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h2, 3'h0));
      rd(A_FLG, 33'h2, "flags ctc");
      wr(A_FLG, 32'h00000003);
      // Force presets the latch, with no flag, before the pin drives.
      wr(A_CTL, ctl(1'b0, 2'h1, 2'h0, 3'h0));
      wr(A_CTL, ctl(1'b1, 2'h1, 2'h0, 3'h0));
      wr(A_PRT, 32'h00000002);
      cyc(2);
      check("pin forced", {31'h0, oc_pin}, 33'h3);
      rd(A_FLG, 33'h0, "flags force");
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
      wr(A_CTL, ctl(1'b1, 2'h0, 2'h0, 3'h0));
      cyc(2);
      check("pin port", {31'h0, oc_pin}, 33'h2);
      rd(A_PRT, 33'hA, "latch act0");
      wr(A_CTL, ctl(1'b0, 2'h1, 2'h3, 3'h0));
      wr(A_CTL, ctl(1'b1, 2'h1, 2'h3, 3'h0));
      rd(A_PRT, 33'hA, "latch pwm");
      // A second reset mid-run must clear the latch again.
      @(posedge pclk);
      presetn <= 1'b0;
      cyc(3);
      presetn <= 1'b1;
      rd(A_PRT, 33'h0, "latch reset");
      // A new action setting governs the very next real match.
      wr(A_CMP, 32'h00000005);
      wr(A_CTL, ctl(1'b0, 2'h1, 2'h0, 3'h1));
      cyc(20);
      wr(A_CTL, ctl(1'b0, 2'h1, 2'h0, 3'h0));
      rd(A_PRT, 33'h8, "latch match");
      // Any 64 clocks hold exactly eight divide-by-8 ticks, whatever
      // the prescaler phase; then only falling pin edges count.
      wr(A_CNT, 32'h00000000);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h2));
      cyc(61);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h6));
      repeat (3) begin
         cyc(4);
         ext_clk_pin <= 1'b1;
         cyc(4);
         ext_clk_pin <= 1'b0;
      end
      cyc(8);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
      rd(A_CNT, 33'h0B, "count div ext");
      // Phase correct: compare writes wait in the buffer until the top.
      wr(A_FLG, 32'h00000003);
      wr(A_CNT, 32'h000000F0);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h1, 3'h0));
      wr(A_CMP, 32'h00000033);
      rd(A_CMP, 33'h33, "cmp buffer");
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h1, 3'h1));
      cyc(17);
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h1, 3'h0));
      rd(A_CNT, 33'hFA, "count pc");
      rd(A_FLG, 33'h0, "flags pc");
      wr(A_CTL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
      rd(A_CMP, 33'h33, "cmp loaded");
      end_sim();
   end
endmodule : tb
